// file: logic/usd_pkg.sv
/*
  constants, types and shared decode for the shadow rx/tx data port of a uart.
  assumes the register bus offers a full 32-bit byte address and that the
  baud tick and line control come from the surrounding uart.
*/
//
// How it works
// - this single full address is the only alias of rx buffer and tx holding decoded; word-spaced neighbours are unmapped.
// - a read returns the received byte in bits 7:0, serial or infrared input.
// - read data is valid only while the rx data valid flag is set.
// - fifos off: a new byte overwrites an unread buffer and flags overrun.
// - fifos on: a read returns the oldest byte at the rx fifo head.
// - rx fifo full: stored bytes kept, incoming byte dropped, overrun raised.
// - a write queues bits 7:0 for serial output or active-low infrared output.
// - fifos off: a write clears the empty flag; later writes replace the byte.
// - fifos on: writes accepted until the tx fifo, depth sixteen, is full.
// - a write to a full tx fifo is dropped, contents unchanged.
package usd_pkg;

  // ----------------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------------
  localparam logic [31:0] USD_ALIAS_ADDR     = 32'h5000_106c;
  localparam int          USD_DATA_LSB       = 0;
  localparam int          USD_DATA_MSB       = 7;
  localparam int          USD_REG_WIDTH      = 16;
  localparam logic [15:0] USD_ALIAS_RESET    = 16'h0000;

  // ----------------------------------------------------------------------
  // sizes and counts
  // ----------------------------------------------------------------------
  localparam int          USD_FIFO_DEPTH     = 16;
  localparam int          USD_CHAR_BITS      = 8;
  localparam logic [3:0]  USD_LAST_DATA_BIT  = 4'h7;
  localparam logic        USD_LINE_IDLE      = 1'b1;

  typedef enum logic [1:0] {
    USD_RX_IDLE,
    USD_RX_DATA,
    USD_RX_STOP
  } usd_rx_state_type;

  typedef enum logic [1:0] {
    USD_TX_IDLE,
    USD_TX_START,
    USD_TX_DATA,
    USD_TX_STOP
  } usd_tx_state_type;

  // shared by the read and the write path
  function automatic logic usd_addr_hit(input logic [31:0] addr);
    usd_addr_hit = (addr == USD_ALIAS_ADDR);
  endfunction

endpackage

// file: logic/usd_fifo_if.sv
/*
  handshake bundle between the shadow port and one of its character fifos.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface usd_fifo_if #(
  parameter int WIDTH = 8,
  parameter int CW    = 5
);
  logic             push;
  logic             pop;
  logic             flush;
  logic [WIDTH-1:0] wdata;
  logic [WIDTH-1:0] rdata;
  logic             full;
  logic             empty;
  logic [CW-1:0]    count;

  modport owner (input push, pop, flush, wdata, output rdata, full, empty, count);
  modport user  (output push, pop, flush, wdata, input rdata, full, empty, count);
endinterface // usd_fifo_if

// file: logic/usd_fifo.sv
/*
  synchronous character fifo with head read-out and flush.
  drops a push when full unless the user pops in the same cycle.
*/
`timescale 1ns/1ps
module usd_fifo #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8,
  parameter int CW    = 5
) (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  // fifo port
  usd_fifo_if.owner f
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    wr_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             do_push;
  logic             do_pop;

  // a push into a full fifo only lands if a pop frees the slot
  assign do_push = f.push && (!f.full || f.pop);
  assign do_pop  = f.pop && !f.empty;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (clk_en_in) begin
      if (f.flush) begin
        rd_ptr_reg <= '0;
        wr_ptr_reg <= '0;
        count_reg  <= '0;
      end else begin
        if (do_push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
        if (do_pop)  rd_ptr_reg <= ptr_inc(rd_ptr_reg);
        count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
      end
    end
  end

  // storage has no reset; contents are don't-care until counted in
  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in && do_push && !f.flush) begin
      mem_reg[wr_ptr_reg] <= f.wdata;
    end
  end

  assign f.rdata = mem_reg[rd_ptr_reg];
  assign f.count = count_reg;
  assign f.empty = (count_reg == '0);
  assign f.full  = (count_reg == CW'(DEPTH));
endmodule // usd_fifo

// file: logic/usd_shadow_port.sv
/*
  shadow rx/tx data alias of a uart with a minimal serial engine behind it.
  assumes: one bit_tick_in pulse per bit time from the uart baud logic,
  fifo enable and infrared mode driven by the uart control registers.
*/
`timescale 1ns/1ps
module usd_shadow_port
  import usd_pkg::*;
#(
  parameter int FIFO_DEPTH = USD_FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  // register port
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // control from the uart
  input  wire logic        fifo_enable_in,
  input  wire logic        ir_mode_in,
  input  wire logic        bit_tick_in,
  // status to the uart
  output logic             rx_data_valid_out,
  output logic             tx_holding_empty_out,
  output logic             overrun_out,
  // line
  input  wire logic        serial_rx_in,
  input  wire logic        ir_rx_in,
  output logic             serial_tx_out,
  output logic             ir_tx_n_out
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  usd_fifo_if #(.WIDTH(USD_CHAR_BITS), .CW(CW)) rxf ();
  usd_fifo_if #(.WIDTH(USD_CHAR_BITS), .CW(CW)) txf ();

  logic                     host_rd;
  logic                     host_wr;
  logic                     fifo_en_d_reg;
  logic                     mode_flip;
  logic                     line_in;
  logic [USD_CHAR_BITS-1:0] rx_buffer_reg;
  logic                     rx_buf_full_reg;
  logic [USD_CHAR_BITS-1:0] tx_holding_reg;
  logic                     tx_hold_full_reg;
  logic                     tx_take;
  logic                     tx_avail;
  logic [USD_CHAR_BITS-1:0] tx_next_byte;
  logic                     overrun_reg;
  logic [31:0]              rdata_reg;

  usd_rx_state_type         rx_state_reg;
  logic [3:0]               rx_bit_reg;
  logic [USD_CHAR_BITS-1:0] rx_shift_reg;
  logic                     rx_done_reg;
  logic [USD_CHAR_BITS-1:0] rx_byte_reg;

  usd_tx_state_type         tx_state_reg;
  logic [3:0]               tx_bit_reg;
  logic [USD_CHAR_BITS-1:0] tx_shift_reg;
  logic                     tx_line_reg;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  assign host_rd = rd_in && usd_addr_hit(addr_in);
  assign host_wr = wr_in && usd_addr_hit(addr_in);

  // ----------------------------------------------------------------------
  // fifos; a change of fifo enable empties both so no stale bytes leak
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fifo_en_d_reg <= 1'b0;
    end else if (clk_en_in) begin
      fifo_en_d_reg <= fifo_enable_in;
    end
  end
  assign mode_flip = fifo_en_d_reg != fifo_enable_in;

  usd_fifo #(.DEPTH(FIFO_DEPTH), .WIDTH(USD_CHAR_BITS), .CW(CW)) u_rx_fifo (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .f          (rxf)
  );

  usd_fifo #(.DEPTH(FIFO_DEPTH), .WIDTH(USD_CHAR_BITS), .CW(CW)) u_tx_fifo (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .f          (txf)
  );

  // full rx fifo drops the new byte: push only lands on a same-cycle pop
  assign rxf.push  = fifo_enable_in && rx_done_reg;
  assign rxf.wdata = rx_byte_reg;
  assign rxf.pop   = fifo_enable_in && host_rd;
  assign rxf.flush = mode_flip;

  assign txf.push  = fifo_enable_in && host_wr && !txf.full;
  assign txf.wdata = wdata_in[USD_DATA_MSB:USD_DATA_LSB];
  assign txf.pop   = fifo_enable_in && tx_take;
  assign txf.flush = mode_flip;

  // ----------------------------------------------------------------------
  // rx buffer for fifo-off mode
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_buffer_reg   <= USD_ALIAS_RESET[USD_DATA_MSB:USD_DATA_LSB];
      rx_buf_full_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (!fifo_enable_in && rx_done_reg) begin
        rx_buffer_reg   <= rx_byte_reg;
        rx_buf_full_reg <= 1'b1;
      end else if (!fifo_enable_in && host_rd) begin
        rx_buf_full_reg <= 1'b0;
      end else if (mode_flip) begin
        rx_buf_full_reg <= 1'b0;
      end
    end
  end

  // overrun: one-cycle pulse to the line status logic
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      overrun_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (fifo_enable_in) begin
        overrun_reg <= rx_done_reg && rxf.full && !host_rd;
      end else begin
        overrun_reg <= rx_done_reg && rx_buf_full_reg && !host_rd;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en_in) begin
      rdata_reg <= 32'h0000_0000; // unmapped and idle read as zero
      if (host_rd) begin
        // upper bits stay zero; the byte is meaningful only if valid was set
        rdata_reg[USD_DATA_MSB:USD_DATA_LSB] <=
          fifo_enable_in ? rxf.rdata : rx_buffer_reg;
      end
    end
  end

  // ----------------------------------------------------------------------
  // tx holding for fifo-off mode; a write beats the transmitter's take
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_holding_reg   <= USD_ALIAS_RESET[USD_DATA_MSB:USD_DATA_LSB];
      tx_hold_full_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (!fifo_enable_in && host_wr) begin
        tx_holding_reg   <= wdata_in[USD_DATA_MSB:USD_DATA_LSB];
        tx_hold_full_reg <= 1'b1;
      end else if ((!fifo_enable_in && tx_take) || mode_flip) begin
        tx_hold_full_reg <= 1'b0;
      end
    end
  end

  assign tx_avail     = fifo_enable_in ? !txf.empty : tx_hold_full_reg;
  assign tx_next_byte = fifo_enable_in ? txf.rdata : tx_holding_reg;
  assign tx_take      = (tx_state_reg == USD_TX_IDLE) && bit_tick_in && tx_avail
                        && !mode_flip;

  // ----------------------------------------------------------------------
  // receiver: one sample per bit tick, lsb first; a bad stop bit drops it
  // ----------------------------------------------------------------------
  // infrared input pulses high for a zero bit
  assign line_in = ir_mode_in ? !ir_rx_in : serial_rx_in;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_state_reg <= USD_RX_IDLE;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_done_reg  <= 1'b0;
      rx_byte_reg  <= 8'h00;
    end else if (clk_en_in) begin
      rx_done_reg <= 1'b0;
      if (bit_tick_in) begin
        case (rx_state_reg)
          USD_RX_IDLE: begin
            if (line_in != USD_LINE_IDLE) begin
              rx_state_reg <= USD_RX_DATA;
              rx_bit_reg   <= 4'h0;
            end
          end
          USD_RX_DATA: begin
            rx_shift_reg <= {line_in, rx_shift_reg[USD_CHAR_BITS-1:1]};
            rx_bit_reg   <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == USD_LAST_DATA_BIT) begin
              rx_state_reg <= USD_RX_STOP;
            end
          end
          USD_RX_STOP: begin
            rx_state_reg <= USD_RX_IDLE;
            if (line_in == USD_LINE_IDLE) begin
              rx_done_reg <= 1'b1;
              rx_byte_reg <= rx_shift_reg;
            end
          end
          default: begin
            rx_state_reg <= USD_RX_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_state_reg <= USD_TX_IDLE;
      tx_bit_reg   <= 4'h0;
      tx_shift_reg <= 8'h00;
      tx_line_reg  <= USD_LINE_IDLE;
    end else if (clk_en_in) begin
      if (bit_tick_in) begin
        case (tx_state_reg)
          USD_TX_IDLE: begin
            tx_line_reg <= USD_LINE_IDLE;
            if (tx_take) begin
              tx_shift_reg <= tx_next_byte;
              tx_state_reg <= USD_TX_START;
            end
          end
          USD_TX_START: begin
            tx_line_reg  <= 1'b0;
            tx_bit_reg   <= 4'h0;
            tx_state_reg <= USD_TX_DATA;
          end
          USD_TX_DATA: begin
            tx_line_reg  <= tx_shift_reg[0];
            tx_shift_reg <= {1'b0, tx_shift_reg[USD_CHAR_BITS-1:1]};
            tx_bit_reg   <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == USD_LAST_DATA_BIT) begin
              tx_state_reg <= USD_TX_STOP;
            end
          end
          USD_TX_STOP: begin
            tx_line_reg  <= USD_LINE_IDLE;
            tx_state_reg <= USD_TX_IDLE;
          end
          default: begin
            tx_state_reg <= USD_TX_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign rdata_out            = rdata_reg;
  assign overrun_out          = overrun_reg;
  assign rx_data_valid_out    = fifo_enable_in ? !rxf.empty : rx_buf_full_reg;
  // software must wait for this before writing; extra writes are handled
  assign tx_holding_empty_out = fifo_enable_in ? txf.empty : !tx_hold_full_reg;
  // infrared output is active low, so a zero bit drives it low
  assign serial_tx_out        = ir_mode_in ? USD_LINE_IDLE : tx_line_reg;
  assign ir_tx_n_out          = ir_mode_in ? tx_line_reg : USD_LINE_IDLE;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_read_upper_zero: assert property (
    clk_en_in && host_rd |=> rdata_out[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  a_unmapped_read_zero: assert property (
    clk_en_in && rd_in && !usd_addr_hit(addr_in) |=> rdata_out == 32'h0)
    else $error("unmapped read returned data");

  a_buffer_overrun_flag: assert property (
    clk_en_in && !fifo_enable_in && rx_done_reg && rx_buf_full_reg && !host_rd
    |=> overrun_out && rx_buffer_reg == $past(rx_byte_reg))
    else $error("overwrite without overrun");

  a_fifo_head_read: assert property (
    clk_en_in && fifo_enable_in && host_rd && !rxf.empty
    |=> rdata_out[7:0] == $past(rxf.rdata))
    else $error("read did not return fifo head");

  a_full_rx_discard: assert property (
    clk_en_in && fifo_enable_in && !mode_flip && rx_done_reg && rxf.full && !host_rd
    |=> overrun_out && $stable(rxf.count))
    else $error("full rx fifo changed on arrival");

  a_write_clears_empty: assert property (
    clk_en_in && !fifo_enable_in && host_wr ##1 !fifo_enable_in
    |-> !tx_holding_empty_out)
    else $error("write left holding empty");

  a_full_tx_drop: assert property (
    clk_en_in && fifo_enable_in && !mode_flip && host_wr && txf.full && !tx_take
    |=> $stable(txf.count))
    else $error("write to full tx fifo stored");

  a_last_pop_invalid: assert property (
    clk_en_in && fifo_enable_in && !mode_flip && host_rd && rxf.count == CW'(1)
    && !rx_done_reg ##1 fifo_enable_in |-> !rx_data_valid_out)
    else $error("valid stayed after last pop");

  a_tx_fifo_accept: assert property (
    clk_en_in && fifo_enable_in && !mode_flip && host_wr && !txf.full && !tx_take
    |=> txf.count == $past(txf.count) + CW'(1))
    else $error("write to tx fifo with room not stored");

  a_rx_push_valid: assert property (
    clk_en_in && fifo_enable_in && !mode_flip && rxf.push ##1 fifo_enable_in
    |-> rx_data_valid_out)
    else $error("arrival left rx fifo empty");

  a_take_sets_empty: assert property (
    clk_en_in && !fifo_enable_in && !mode_flip && tx_take && !host_wr ##1 !fifo_enable_in
    |-> tx_holding_empty_out)
    else $error("take left holding full");

endmodule // usd_shadow_port

// file: tb/usd_remote_model.sv
/*
  far-side transceiver for the shadow data port: sends queued bytes as 8n1
  frames and collects the frames that the port transmits.
  assumes the same clock and bit tick as the port; infrared is plain nrz.
*/
`timescale 1ns/1ps
module usd_remote_model (
  // clock, reset and baud
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic bit_tick_in,
  input  wire logic ir_mode_in,
  // lines driven by the port
  input  wire logic serial_line_in,
  input  wire logic ir_line_n_in,
  // lines into the port
  output logic      serial_line_out,
  output logic      ir_line_out
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  logic [9:0] frame;
  logic [7:0] r_byte;
  logic       out_bit;
  int         s_cnt;
  int         r_cnt;
  wire  logic line_bit = ir_mode_in ? ir_line_n_in : serial_line_in;

  // unused line idles: serial high, infrared no pulse
  assign serial_line_out = ir_mode_in ? 1'b1 : out_bit;
  assign ir_line_out     = ir_mode_in ? ~out_bit : 1'b0;

  // ----------------------------------------------------------------------
  // sender: start, data lsb first, one stop bit
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_bit <= 1'b1;
      s_cnt   <= 0;
    end else if (bit_tick_in) begin
      if (s_cnt != 0) begin
        out_bit <= frame[s_cnt];
        s_cnt   <= (s_cnt == 9) ? 0 : s_cnt + 1;
      end else if (send_q.size() > 0) begin
        frame = {1'b1, send_q.pop_front(), 1'b0};
        out_bit <= 1'b0;
        s_cnt   <= 1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // receiver: a frame with a bad stop bit is dropped
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_cnt <= 0;
    end else if (bit_tick_in) begin
      if (r_cnt == 0) begin
        if (line_bit == 1'b0) r_cnt <= 1;
      end else if (r_cnt < 9) begin
        r_byte[r_cnt-1] <= line_bit;
        r_cnt           <= r_cnt + 1;
      end else begin
        if (line_bit) got_q.push_back(r_byte);
        r_cnt <= 0;
      end
    end
  end
endmodule // usd_remote_model

// file: tb/usd_shadow_port_test.sv
/*
  self-checking bench for the shadow data port, rx/tx in both fifo modes.
  assumes the remote model on the line side and a bit tick every 4 clocks.
*/
`timescale 1ns/1ps
module usd_shadow_port_test;
  import usd_pkg::*;
  // fifo kept small so full and overrun cases stay short
  localparam int DEPTH = 4;
  localparam int LIMIT = 20000;
  logic        sys_clk_in, reset_n_in, clk_en_in, wr_in, rd_in, bit_tick_in, tick_run;
  logic        fifo_enable_in, ir_mode_in, serial_rx_in, ir_rx_in;
  logic        rx_data_valid_out, tx_holding_empty_out, overrun_out;
  logic        serial_tx_out, ir_tx_n_out;
  logic [31:0] addr_in, wdata_in, rdata_out, rd_val;
  int          err_count = 0, checks_done = 0, cycles = 0, tick_div = 0, ovr_cnt = 0, base;

  usd_shadow_port #(.FIFO_DEPTH(DEPTH)) dut (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .fifo_enable_in(fifo_enable_in), .ir_mode_in(ir_mode_in),
    .bit_tick_in(bit_tick_in), .rx_data_valid_out(rx_data_valid_out),
    .tx_holding_empty_out(tx_holding_empty_out), .overrun_out(overrun_out),
    .serial_rx_in(serial_rx_in), .ir_rx_in(ir_rx_in),
    .serial_tx_out(serial_tx_out), .ir_tx_n_out(ir_tx_n_out));

  usd_remote_model partner (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .bit_tick_in(bit_tick_in),
    .ir_mode_in(ir_mode_in), .serial_line_in(serial_tx_out), .ir_line_n_in(ir_tx_n_out),
    .serial_line_out(serial_rx_in), .ir_line_out(ir_rx_in));

  // ----------------------------------------------------------------------
  // clock, baud tick, overrun count, timeout
  // ----------------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    tick_div    <= (tick_div == 3) ? 0 : tick_div + 1;
    bit_tick_in <= tick_run && (tick_div == 3);
    if (overrun_out === 1'b1) ovr_cnt <= ovr_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      summarize();
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_bit(input string what, input logic seen, input logic exp);
    check(what, {31'h0, seen}, {31'h0, exp});
  endtask
  // one bus cycle; strobes hold until the next bus_cycle call changes them
  task automatic bus_cycle(input logic w, input logic r, input logic [31:0] a,
                           input logic [31:0] d);
    @(posedge sys_clk_in);
    wr_in    <= w;
    rd_in    <= r;
    addr_in  <= a;
    wdata_in <= d;
  endtask
  task automatic bus_read(input logic [31:0] a, output logic [31:0] v);
    bus_cycle(1'b0, 1'b1, a, 32'h0);
    bus_cycle(1'b0, 1'b0, 32'h0, 32'h0);
    #1 v = rdata_out;
  endtask
  task automatic wait_valid();
    for (int i = 0; i < 200; i++) begin
      if (rx_data_valid_out === 1'b1) break;
      @(posedge sys_clk_in);
      #1;
    end
    check_bit("rx valid", rx_data_valid_out, 1'b1);
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 2000; i++) begin
      if (partner.got_q.size() >= n) break;
      @(posedge sys_clk_in);
    end
    repeat (60) @(posedge sys_clk_in);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset_n_in = 1'b0;
    {wr_in, rd_in, fifo_enable_in, ir_mode_in} = 4'h0;
    {addr_in, wdata_in} = 64'h0;
    tick_run  = 1'b1;
    clk_en_in = 1'b1;
    repeat (5) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    @(posedge sys_clk_in);
    #1 check("rdata reset", rdata_out, 32'h0);
    check_bit("valid reset", rx_data_valid_out, 1'b0);
    check_bit("empty reset", tx_holding_empty_out, 1'b1);
    check_bit("line reset", serial_tx_out & ir_tx_n_out, 1'b1);
    // unmapped accesses, then fifo-off replace of the held byte
    bus_read(USD_ALIAS_ADDR - 32'h4, rd_val);
    check("unmapped read", rd_val, 32'h0);
    tick_run <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    // a strobe while the clock enable is low must leave no trace
    clk_en_in <= 1'b0;
    bus_cycle(1'b1, 1'b0, USD_ALIAS_ADDR, 32'h77);
    bus_cycle(1'b0, 1'b0, 32'h0, 32'h0);
    #1 check_bit("frozen write", tx_holding_empty_out, 1'b1);
    clk_en_in <= 1'b1;
    bus_cycle(1'b1, 1'b0, USD_ALIAS_ADDR + 32'h4, 32'h55);
    bus_cycle(1'b1, 1'b0, USD_ALIAS_ADDR, 32'h0000_00a5);
    bus_cycle(1'b1, 1'b0, USD_ALIAS_ADDR, 32'hffff_ff3c);
    bus_cycle(1'b0, 1'b0, 32'h0, 32'h0);
    #1 check_bit("empty after write", tx_holding_empty_out, 1'b0);
    tick_run <= 1'b1;
    wait_got(1);
    check("tx count", partner.got_q.size(), 1);
    check("tx byte", {24'h0, partner.got_q[0]}, 32'h3c);
    check_bit("empty again", tx_holding_empty_out, 1'b1);
    // fifo-off receive and overwrite
    partner.send_q.push_back(8'h96);
    wait_valid();
    bus_read(USD_ALIAS_ADDR, rd_val);
    check("rx byte", rd_val, 32'h96);
    check_bit("valid after read", rx_data_valid_out, 1'b0);
    base = ovr_cnt;
    partner.send_q.push_back(8'h11);
    partner.send_q.push_back(8'h22);
    repeat (120) @(posedge sys_clk_in);
    check("overwrite overrun", ovr_cnt - base, 1);
    bus_read(USD_ALIAS_ADDR, rd_val);
    check("overwritten byte", rd_val, 32'h22);
    // infrared both ways
    ir_mode_in <= 1'b1;
    partner.got_q.delete();
    check_bit("empty before write", tx_holding_empty_out, 1'b1);
    bus_cycle(1'b1, 1'b0, USD_ALIAS_ADDR, 32'h4b);
    bus_cycle(1'b0, 1'b0, 32'h0, 32'h0);
    wait_got(1);
    check("ir tx byte", {24'h0, partner.got_q[0]}, 32'h4b);
    partner.send_q.push_back(8'hd2);
    wait_valid();
    bus_read(USD_ALIAS_ADDR, rd_val);
    check("ir rx byte", rd_val, 32'hd2);
    ir_mode_in     <= 1'b0;
    fifo_enable_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    // rx fifo fills, one byte too many
    base = ovr_cnt;
    for (int i = 1; i <= DEPTH + 1; i++) partner.send_q.push_back(8'(i));
    repeat (260) @(posedge sys_clk_in);
    check("full overrun", ovr_cnt - base, 1);
    for (int i = 1; i <= DEPTH; i++) begin
      bus_read(USD_ALIAS_ADDR, rd_val);
      check("fifo head", rd_val, 32'(i));
      check_bit("valid per pop", rx_data_valid_out, 1'(i < DEPTH));
    end
    // tx fifo fills, extra write dropped
    tick_run <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    partner.got_q.delete();
    for (int i = 0; i <= DEPTH; i++) bus_cycle(1'b1, 1'b0, USD_ALIAS_ADDR, 32'ha0 + 32'(i));
    bus_cycle(1'b0, 1'b0, 32'h0, 32'h0);
    #1 check_bit("fifo not empty", tx_holding_empty_out, 1'b0);
    tick_run <= 1'b1;
    wait_got(DEPTH);
    check("tx fifo count", partner.got_q.size(), DEPTH);
    for (int i = 0; i < DEPTH; i++) begin
      check("tx fifo byte", {24'h0, partner.got_q[i]}, 32'ha0 + 32'(i));
    end
    summarize();
  end
endmodule // usd_shadow_port_test
